/* File: ebgp_defines.vh */
// register map, field positions and reset values of the three gpio ports
// assumes word-aligned classic wishbone access with 32-bit data
`ifndef EBGP_DEFINES_VH
`define EBGP_DEFINES_VH

// byte offsets, one aligned word per register
`define EBGP_OFS_H_DIR 8'h00
`define EBGP_OFS_H_PIN 8'h04
`define EBGP_OFS_H_LAT 8'h08
`define EBGP_OFS_J_DIR 8'h0C
`define EBGP_OFS_J_PIN 8'h10
`define EBGP_OFS_J_LAT 8'h14
`define EBGP_OFS_K_DIR 8'h18
`define EBGP_OFS_K_PIN 8'h1C
`define EBGP_OFS_K_LAT 8'h20
`define EBGP_OFS_CFG 8'h24

// converter_pin_config fields
`define EBGP_CFG_VREF_HI 5
`define EBGP_CFG_VREF_LO 4
`define EBGP_CFG_PCFG_HI 3
`define EBGP_CFG_PCFG_LO 0
`define EBGP_CFG_MASK 8'h3F

// reset values
`define EBGP_DIR_RST 8'hFF
`define EBGP_CFG_RST 8'h00

// first upper port h pin that can turn analog
`define EBGP_H_ANA_LSB 4

`endif

/* File: ebgp_pins.sv */
// pin model of one port: driven bits follow the block
// assumes an outside source holds every released pin
`timescale 1ns/10ps
module ebgp_pins (
  // from the block
  input wire [7:0] o_i,
  input wire [7:0] oe_i,
  // outside source
  input wire [7:0] ext_i,
  // level seen on the pins
  output wire [7:0] lvl_o
);
  assign lvl_o = (o_i & oe_i) | (ext_i & ~oe_i);
endmodule // ebgp_pins

/* File: ebgp_top.v */
// three 8-bit gpio ports h, j, k with direction, pin-access and latch registers,
// plus the converter pin configuration register that steers port h bits 7:4.
// assumes a classic wishbone master on clk_i and pins synchronous to clk_i.
//
// What this block does
// - direction one: driver off, pin is input
// - direction zero: drive latch onto pin
// - latch register read-modify-write uses latch
// - pin register reads pins, writes latch
// - latch register reads and writes latch
// - latch undefined on power-on, kept otherwise
// - port h 7:4 double as channels 12-15
// - each pin has own direction bit
// - config: 7:6 unused, vref 5:4, pins 3:0
// - port j: eight bits, full register set
// - port k: eight bits, full register set
// - after power-on h 7:4 inputs, read zero
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`include "ebgp_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// one 8-bit port: direction and output latch, pin drive
module ebgp_port #(
  parameter WIDTH = 8
) (
  // clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire other_rst_i,
  // register writes
  input wire dir_we_i,
  input wire lat_we_i,
  input wire [WIDTH-1:0] wdata_i,
  // register state
  output wire [WIDTH-1:0] dir_o,
  output wire [WIDTH-1:0] lat_o,
  // pin drive
  output wire [WIDTH-1:0] pin_o,
  output wire [WIDTH-1:0] pin_oe_o
);

  reg [WIDTH-1:0] dir_ff;
  reg [WIDTH-1:0] lat_ff;
  // the port holds only its own two registers, so the three ports stay identical
  // and a pin only ever sees its own direction and latch bit

  // per-pin direction
  // every reset returns all pins to input
  always @(posedge clk_i) begin
    if (rst_i || other_rst_i) begin
      dir_ff <= `EBGP_DIR_RST;
    end else if (dir_we_i) begin
      dir_ff <= wdata_i;
    end
  end

  // latch never reset
  // no reset term: contents are unknown after power-on and survive other resets
  always @(posedge clk_i) begin
    if (lat_we_i) begin
      lat_ff <= wdata_i;
    end
  end

  assign dir_o = dir_ff;
  assign lat_o = lat_ff;
  assign pin_o = lat_ff;
  assign pin_oe_o = ~dir_ff;

endmodule // ebgp_port

////////////////////////////////////////////////////////////////////////////////
module ebgp_top #(
  parameter WIDTH = 8
) (
  // clock and power-on reset
  input wire clk_i,
  input wire rst_i,
  // any other reset: directions set to all inputs, config cleared, latches kept
  input wire other_rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // port h pins
  input wire [WIDTH-1:0] port_h_pin_i,
  output wire [WIDTH-1:0] port_h_pin_o,
  output wire [WIDTH-1:0] port_h_pin_oe_o,
  // port j pins
  input wire [WIDTH-1:0] port_j_pin_i,
  output wire [WIDTH-1:0] port_j_pin_o,
  output wire [WIDTH-1:0] port_j_pin_oe_o,
  // port k pins
  input wire [WIDTH-1:0] port_k_pin_i,
  output wire [WIDTH-1:0] port_k_pin_o,
  output wire [WIDTH-1:0] port_k_pin_oe_o,
  // to the analog input multiplexer
  output wire [3:0] analog_sel_o,
  output wire [1:0] vref_sel_o
);

  reg ack_ff;
  reg [31:0] rdat_ff;
  reg [5:0] cfg_ff;
  reg [7:0] nxt_rdat;
  reg [3:0] ana_mask;
  wire req;
  wire wr;
  wire [7:0] wd;
  wire [WIDTH-1:0] h_dir;
  wire [WIDTH-1:0] h_lat;
  wire [WIDTH-1:0] j_dir;
  wire [WIDTH-1:0] j_lat;
  wire [WIDTH-1:0] k_dir;
  wire [WIDTH-1:0] k_lat;
  wire [WIDTH-1:0] h_pin_rd;
  wire [3:0] pcfg;
  // one hit line per register offset, shared by the write strobes
  wire hit_h_dir;
  wire hit_h_pin;
  wire hit_h_lat;
  wire hit_j_dir;
  wire hit_j_pin;
  wire hit_j_lat;
  wire hit_k_dir;
  wire hit_k_pin;
  wire hit_k_lat;
  wire hit_cfg;
  // per-register write strobes, all qualified by the ack edge
  wire h_dir_we;
  wire h_lat_we;
  wire j_dir_we;
  wire j_lat_we;
  wire k_dir_we;
  wire k_lat_we;
  wire cfg_we;
  // full-width copy of the config reset value, cut to the six stored bits
  wire [7:0] cfg_rst;

  //////////////////////////////////////////////////////////////////////////////
  // bus handshake
  assign req = wb_cyc_i & wb_stb_i;
  // writes land at the edge where ack is high, the same edge the master samples it
  assign wr = req & wb_we_i & ack_ff & wb_sel_i[0];
  assign wd = wb_dat_i[7:0];

  // one wait state: ack in the cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // address decode
  // the whole byte offset is compared, so no register shows up at an alias
  assign hit_h_dir = (wb_adr_i == `EBGP_OFS_H_DIR);
  assign hit_h_pin = (wb_adr_i == `EBGP_OFS_H_PIN);
  assign hit_h_lat = (wb_adr_i == `EBGP_OFS_H_LAT);
  assign hit_j_dir = (wb_adr_i == `EBGP_OFS_J_DIR);
  assign hit_j_pin = (wb_adr_i == `EBGP_OFS_J_PIN);
  assign hit_j_lat = (wb_adr_i == `EBGP_OFS_J_LAT);
  assign hit_k_dir = (wb_adr_i == `EBGP_OFS_K_DIR);
  assign hit_k_pin = (wb_adr_i == `EBGP_OFS_K_PIN);
  assign hit_k_lat = (wb_adr_i == `EBGP_OFS_K_LAT);
  assign hit_cfg = (wb_adr_i == `EBGP_OFS_CFG);

  // write strobes
  // pin write hits latch
  // latch write hits latch
  // the pin-access and latch-only offsets load one latch, there is no second copy
  assign h_dir_we = wr & hit_h_dir;
  assign h_lat_we = wr & (hit_h_pin | hit_h_lat);
  assign j_dir_we = wr & hit_j_dir;
  assign j_lat_we = wr & (hit_j_pin | hit_j_lat);
  assign k_dir_we = wr & hit_k_dir;
  assign k_lat_we = wr & (hit_k_pin | hit_k_lat);
  assign cfg_we = wr & hit_cfg;

  //////////////////////////////////////////////////////////////////////////////
  // converter pin configuration
  assign pcfg = cfg_ff[`EBGP_CFG_PCFG_HI:`EBGP_CFG_PCFG_LO];

  assign cfg_rst = `EBGP_CFG_RST;

  // config cleared on reset
  // bits 7:6 are not stored and read zero
  always @(posedge clk_i) begin
    if (rst_i || other_rst_i) begin
      cfg_ff <= cfg_rst[5:0];
    end else if (cfg_we) begin
      cfg_ff <= wd[5:0];
    end
  end

  // upper h to channels
  // pin i+4 goes analog while pcfg < 4-i; zero makes all four analog, 4 or more none
  // channels peel off from pin 7 downward, so a low pcfg keeps the most pins analog
  always @* begin
    case (pcfg)
      4'h0: ana_mask = 4'hF;
      4'h1: ana_mask = 4'h7;
      4'h2: ana_mask = 4'h3;
      4'h3: ana_mask = 4'h1;
      default: ana_mask = 4'h0;
    endcase
  end

  assign analog_sel_o = ana_mask;
  assign vref_sel_o = cfg_ff[`EBGP_CFG_VREF_HI:`EBGP_CFG_VREF_LO];

  //////////////////////////////////////////////////////////////////////////////
  // the three ports
  // pin write hits latch
  ebgp_port #(.WIDTH(WIDTH)) u_port_h (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .other_rst_i(other_rst_i),
    .dir_we_i(h_dir_we),
    .lat_we_i(h_lat_we),
    .wdata_i(wd),
    .dir_o(h_dir),
    .lat_o(h_lat),
    .pin_o(port_h_pin_o),
    .pin_oe_o(port_h_pin_oe_o)
  );

  ebgp_port #(.WIDTH(WIDTH)) u_port_j (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .other_rst_i(other_rst_i),
    .dir_we_i(j_dir_we),
    .lat_we_i(j_lat_we),
    .wdata_i(wd),
    .dir_o(j_dir),
    .lat_o(j_lat),
    .pin_o(port_j_pin_o),
    .pin_oe_o(port_j_pin_oe_o)
  );

  ebgp_port #(.WIDTH(WIDTH)) u_port_k (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .other_rst_i(other_rst_i),
    .dir_we_i(k_dir_we),
    .lat_we_i(k_lat_we),
    .wdata_i(wd),
    .dir_o(k_dir),
    .lat_o(k_lat),
    .pin_o(port_k_pin_o),
    .pin_oe_o(port_k_pin_oe_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read path
  // analog bits read zero
  assign h_pin_rd = {port_h_pin_i[7:4] & ~ana_mask, port_h_pin_i[3:0]};

  // latch read, not pins
  // unmapped offsets read zero and are still acknowledged
  // pin-access reads of an output return the live pin, so a shorted pin shows up
  always @* begin
    case (wb_adr_i)
      `EBGP_OFS_H_DIR: nxt_rdat = h_dir;
      `EBGP_OFS_H_PIN: nxt_rdat = h_pin_rd;
      `EBGP_OFS_H_LAT: nxt_rdat = h_lat;
      `EBGP_OFS_J_DIR: nxt_rdat = j_dir;
      `EBGP_OFS_J_PIN: nxt_rdat = port_j_pin_i;
      `EBGP_OFS_J_LAT: nxt_rdat = j_lat;
      `EBGP_OFS_K_DIR: nxt_rdat = k_dir;
      `EBGP_OFS_K_PIN: nxt_rdat = port_k_pin_i;
      `EBGP_OFS_K_LAT: nxt_rdat = k_lat;
      `EBGP_OFS_CFG: nxt_rdat = {2'b00, cfg_ff};
      default: nxt_rdat = 8'h00;
    endcase
  end

  // read data is captured as ack rises and held while ack is high
  // capturing one edge early costs the wait state but keeps pin timing off the bus
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff) begin
      rdat_ff <= {24'h00_0000, nxt_rdat};
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule // ebgp_top

/* File: ebgp_top_asserts.sv */
// checker for ebgp_top, sees its ports only
// assumes reset is held before the first request
`timescale 1ns/10ps
module ebgp_top_asserts #(parameter WIDTH = 8) (
  // clock, resets
  input wire clk_i,
  input wire rst_i,
  input wire other_rst_i,
  // bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // pins, mux
  input wire [WIDTH-1:0] port_h_pin_o,
  input wire [WIDTH-1:0] port_h_pin_oe_o,
  input wire [WIDTH-1:0] port_j_pin_o,
  input wire [WIDTH-1:0] port_k_pin_oe_o,
  input wire [3:0] analog_sel_o,
  input wire [1:0] vref_sel_o
);
  // write lands at ack edge, read is taken an edge earlier
  // a concurrent other reset wins over a direction or config write, so leave it out
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0] & !other_rst_i;
  wire rd = wb_cyc_i & wb_stb_i & !wb_we_i & !wb_ack_o;
  wire [7:0] a = wb_adr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_H_DIR: assert property (wr && a == 8'h00 |=> port_h_pin_oe_o == ~$past(wb_dat_i[7:0]))
    else $error("h enable wrong");
  AST_H_LAT: assert property (wr && (a == 8'h04 || a == 8'h08) |=> port_h_pin_o == $past(wb_dat_i[7:0]))
    else $error("h latch wrong");
  AST_J_LAT: assert property (wr && a == 8'h14 |=> port_j_pin_o == $past(wb_dat_i[7:0]))
    else $error("j latch wrong");
  AST_K_DIR: assert property (wr && a == 8'h18 |=> port_k_pin_oe_o == ~$past(wb_dat_i[7:0]))
    else $error("k enable wrong");
  AST_CFG: assert property (wr && a == 8'h24 |=> vref_sel_o == $past(wb_dat_i[5:4]))
    else $error("vref wrong");
  AST_ANA: assert property (wr && a == 8'h24 && wb_dat_i[3:2] != 2'b00 |=> analog_sel_o == 4'h0)
    else $error("analog select wrong");
  // reset itself is the cause here, so it cannot disable
  AST_POR: assert property (disable iff (1'b0) rst_i |=> port_h_pin_oe_o == 8'h00 && analog_sel_o == 4'hf)
    else $error("power-on state wrong");
  AST_RD_ANA: assert property (rd && a == 8'h04 && analog_sel_o == 4'hf |=> wb_dat_o[7:4] == 4'h0)
    else $error("analog bits read high");
  AST_OTHER: assert property (other_rst_i && !wb_ack_o |=> port_h_pin_oe_o == 8'h00 && $stable(port_h_pin_o))
    else $error("other reset wrong");
  C_CFG: cover property (wr && a == 8'h24);
  C_RD: cover property (rd && a == 8'h04 && analog_sel_o == 4'hf);
  C_OTH: cover property (other_rst_i);
endmodule // ebgp_top_asserts
bind ebgp_top ebgp_top_asserts #(.WIDTH(WIDTH)) ebgp_top_asserts_inst (.*);

/* File: eight_bit_gpio_ports_hjk_tb_top.sv */
// bench for ebgp_top: bus tasks, pin models, checks
// assumes fixed outside levels on released pins
`timescale 1ns/10ps
module eight_bit_gpio_ports_hjk_tb_top;
  reg clk_i = 0;
  reg rst_i = 1;
  reg orst = 0;
  reg cyc = 0;
  reg stb = 0;
  reg we = 0;
  reg [7:0] adr = 8'h00;
  reg [3:0] sel = 4'h0;
  reg [31:0] wd = 32'h0000_0000;
  reg [31:0] q;
  wire [23:0] ext = 24'h3c_c3a5;
  wire [31:0] rdat;
  wire ack;
  wire [23:0] po;
  wire [23:0] poe;
  wire [23:0] pl;
  wire [3:0] ana;
  wire [1:0] vref;
  int error_cnt = 0;
  int checks_done = 0;
  int i;
  // 50 MHz clock
  always #10 clk_i = ~clk_i;
  ebgp_top ebgp_top_inst (.clk_i(clk_i), .rst_i(rst_i), .other_rst_i(orst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
    .wb_ack_o(ack), .port_h_pin_i(pl[23:16]), .port_h_pin_o(po[23:16]), .port_h_pin_oe_o(poe[23:16]),
    .port_j_pin_i(pl[15:8]), .port_j_pin_o(po[15:8]), .port_j_pin_oe_o(poe[15:8]),
    .port_k_pin_i(pl[7:0]), .port_k_pin_o(po[7:0]), .port_k_pin_oe_o(poe[7:0]),
    .analog_sel_o(ana), .vref_sel_o(vref));
  // one pin model per port, h on top
  ebgp_pins ebgp_pins_inst [2:0] (.o_i(po), .oe_i(poe), .ext_i(ext), .lvl_o(pl));
  ////////////////////////////////////////
  // verdict and run end
  task end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // compare one result
  task chk(input [31:0] g, input [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; ack is waited for, never assumed
  task xfer(input [7:0] a, input w, input [7:0] d, input [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wd <= {24'h00_0000, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 9) begin
      @(posedge clk_i);
      n++;
    end
    if (ack !== 1'b1) begin
      error_cnt++;
      $display("BAD %0t no ack", $time);
      end_sim;
    end else begin
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    xfer(a, 1'b1, d, 4'h1);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    xfer(a, 1'b0, 8'h00, 4'h1);
    chk(q, e);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({ana, vref, poe}, {4'hf, 2'b00, 24'h00_0000});
    rd(8'h00, 32'h0000_00ff);
    rd(8'h18, 32'h0000_00ff);
    rd(8'h04, 32'h0000_000c);
    wr(8'h24, 8'hff);
    rd(8'h24, 32'h0000_003f);
    chk(vref, 2'b11);
    for (i = 0; i < 5; i++) begin
      wr(8'h24, i[7:0]);
      @(negedge clk_i);
      chk(ana, 4'hf >> i);
    end
    wr(8'h04, 8'ha5);
    wr(8'h00, 8'h0f);
    @(negedge clk_i);
    chk({poe[23:16], po[23:16]}, 16'hf0a5);
    rd(8'h04, 32'h0000_00ac);
    rd(8'h08, 32'h0000_00a5);
    wr(8'h08, q[7:0] | 8'h10);
    rd(8'h08, 32'h0000_00b5);
    wr(8'h24, 8'h00);
    rd(8'h04, 32'h0000_000c);
    wr(8'h14, 8'h5a);
    wr(8'h0c, 8'h00);
    @(negedge clk_i);
    chk({poe[15:8], po[15:8]}, 16'hff5a);
    rd(8'h10, 32'h0000_005a);
    xfer(8'h14, 1'b1, 8'h11, 4'he);
    rd(8'h14, 32'h0000_005a);
    wr(8'h20, 8'hf0);
    wr(8'h18, 8'haa);
    @(negedge clk_i);
    chk({poe[7:0], po[7:0]}, 16'h55f0);
    rd(8'h1c, 32'h0000_00f0);
    rd(8'h28, 32'h0000_0000);
    @(posedge clk_i);
    orst <= 1'b1;
    @(posedge clk_i);
    orst <= 1'b0;
    @(negedge clk_i);
    chk({ana, poe}, {4'hf, 24'h00_0000});
    rd(8'h08, 32'h0000_00b5);
    rd(8'h24, 32'h0000_0000);
    end_sim;
  end
endmodule // eight_bit_gpio_ports_hjk_tb_top
